// ==== design/rest_pkg.sv ====
// Purpose: shared constants for the ring error statistics block
// Assumes: apb slave, 32-bit data, word aligned registers
// Notes: offsets are byte addresses
package rest_pkg;
  // ==========================================================
  // counter indices
  localparam int NUM_CNT = 10;
  localparam int CNT_W = 8;
  localparam logic [3:0] CNT_LINE = 4'h0;
  localparam logic [3:0] CNT_INTERNAL = 4'h1;
  localparam logic [3:0] CNT_BURST = 4'h2;
  localparam logic [3:0] CNT_ARFC = 4'h3;
  localparam logic [3:0] CNT_ABORT = 4'h4;
  localparam logic [3:0] CNT_LOST = 4'h5;
  localparam logic [3:0] CNT_CONGEST = 4'h6;
  localparam logic [3:0] CNT_DUPADDR = 4'h7;
  localparam logic [3:0] CNT_FREQ = 4'h8;
  localparam logic [3:0] CNT_TOKEN = 4'h9;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_ADDR_LO = 8'h10;
  localparam logic [7:0] OFS_ADDR_HI = 8'h14;
  localparam logic [7:0] OFS_LINKS = 8'h18;
  localparam logic [7:0] OFS_OVF = 8'h1C;
  localparam logic [7:0] OFS_CNT_BASE = 8'h20;
  // ==========================================================
  // field positions
  localparam int CTRL_CLR_BIT = 0;
  localparam int ST_OPEN_BIT = 0;
  localparam int ST_SIGLOSS_BIT = 1;
  localparam int ST_HARDERR_BIT = 2;
  localparam int ST_WIREFLT_BIT = 3;
  localparam int IRQ_SIGLOSS_BIT = 0;
  localparam int IRQ_HARDERR_BIT = 1;
  localparam int IRQ_WIREFLT_BIT = 2;
  localparam int IRQ_OVF_BIT = 3;
  localparam int IRQ_W = 4;
  localparam int LINKS_ACT_POS = 8;
  // ==========================================================
  // reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [31:0] ADDR_LO_RST = 32'h0000_0000;
  localparam logic [23:0] ADDR_HI_RST = 24'h00_0000;
  localparam logic [31:0] APB_BAD_DATA = 32'h0000_0000;
endpackage : rest_pkg

// ==== design/rest_counter.sv ====
// Purpose: one wrapping error counter with sticky overflow flag
// Assumes: inc is a one-cycle pulse
// Notes: clear beats an increment on the count, but a wrap in that cycle still sets the flag
`timescale 1ns/1ns
`default_nettype none
module rest_counter #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_inc,
  input wire logic i_clr,
  output logic [W-1:0] o_count,
  output logic o_ovf,
  output logic o_wrap
);
  logic [W-1:0] count_reg;
  logic ovf_reg;
  assign o_wrap = i_inc && (count_reg == {W{1'b1}});
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_clr)
    begin
      count_reg <= '0;
    end
    else if (i_inc)
    begin
      count_reg <= count_reg + 1'b1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ovf_reg <= 1'b0;
    end
    else if (o_wrap)
    begin
      ovf_reg <= 1'b1;
    end
    else if (i_clr)
    begin
      ovf_reg <= 1'b0;
    end
  end
  assign o_count = count_reg;
  assign o_ovf = ovf_reg;
endmodule : rest_counter
`default_nettype wire

// ==== design/rest_link_status.sv ====
// Purpose: ring fault status tracking and lobe de-insertion
// Assumes: fault inputs are levels synchronous to i_clk
// Notes: de-insert latches until software clears via close
`timescale 1ns/1ns
`default_nettype none
module rest_link_status (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_open_req,
  input wire logic i_sig_present,
  input wire logic i_beacon_int,
  input wire logic i_beacon_rx,
  input wire logic i_lobe_fault,
  output logic o_opened,
  output logic o_sig_loss,
  output logic o_hard_err,
  output logic o_wire_fault,
  output logic o_insert
);
  logic opened_reg;
  logic sig_loss_reg;
  logic hard_err_reg;
  logic wire_fault_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sig_loss_reg <= 1'b0;
      hard_err_reg <= 1'b0;
    end
    else
    begin
      sig_loss_reg <= !i_sig_present;
      hard_err_reg <= i_beacon_int || i_beacon_rx;
    end
  end
  // wire fault stays until the adapter is asked to close, so it cannot re-insert on its own
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wire_fault_reg <= 1'b0;
    end
    else if (i_lobe_fault)
    begin
      wire_fault_reg <= 1'b1;
    end
    else if (!i_open_req)
    begin
      wire_fault_reg <= 1'b0;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      opened_reg <= 1'b0;
    end
    else
    begin
      opened_reg <= i_open_req && !i_lobe_fault && !wire_fault_reg;
    end
  end
  assign o_opened = opened_reg;
  assign o_sig_loss = sig_loss_reg;
  assign o_hard_err = hard_err_reg;
  assign o_wire_fault = wire_fault_reg;
  assign o_insert = opened_reg;
endmodule : rest_link_status
`default_nettype wire

// ==== design/rest_stats.sv ====
// Purpose: ring adapter error statistics and status over apb
// Assumes: event inputs are one-cycle pulses synchronous to i_clk
// Notes: apb answers with zero wait states
//
// How it works
// - line errors count only on copied/repeated frames with error-detect still clear
// - line error: code violation in frame or token, or type 1 check error
// - each internal adapter error bumps the internal error counter
// - each burst interrupt from the protocol handler bumps the burst counter
// - own frame returning with address-recognized or frame-copied clear is counted
// - each transmitted abort delimiter is counted
// - in transmit mode, each own frame not returning is counted
// - frame for us refused for lack of buffers is counted
// - frame with our address and recognized/copied already set is counted
// - excessive ring-versus-oscillator frequency difference is counted
// - token protocol violation seen by active monitor is counted
// - signal loss is reported while no ring signal is present
// - hard error is reported on internal or received beacon
// - lobe wire fault is reported and the adapter leaves the ring
// - status shows whether the adapter is opened or closed
// - station address is six adapter bytes plus one access point byte
// - reset-statistics request clears every counter to zero
// - active and configured link counts are reported side by side
`timescale 1ns/1ns
`default_nettype none
module rest_stats #(
  parameter int CNT_WIDTH = rest_pkg::CNT_W,
  parameter int LINK_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // protocol handler events
  input wire logic i_frame_copy_rep,
  input wire logic i_err_detect,
  input wire logic i_cv_frame,
  input wire logic i_cv_token,
  input wire logic i_fcs_err_fmt1,
  input wire logic i_internal_err,
  input wire logic i_burst_int,
  input wire logic i_own_return,
  input wire logic i_ret_addr_rec,
  input wire logic i_ret_copied,
  input wire logic i_abort_tx,
  input wire logic i_tx_mode,
  input wire logic i_frame_lost,
  input wire logic i_rx_for_us_busy,
  input wire logic i_no_buffer,
  input wire logic i_rx_own_addr,
  input wire logic i_rx_addr_rec,
  input wire logic i_rx_copied,
  input wire logic i_freq_err,
  input wire logic i_token_err,
  // ring state
  input wire logic i_open_req,
  input wire logic i_sig_present,
  input wire logic i_beacon_int,
  input wire logic i_beacon_rx,
  input wire logic i_lobe_fault,
  input wire logic i_reset_stats,
  input wire logic [LINK_W-1:0] i_links_active,
  input wire logic [LINK_W-1:0] i_links_config,
  input wire logic i_status_req,
  output logic o_insert,
  output logic [47:0] o_station_addr,
  output logic [7:0] o_station_sap,
  output logic o_irq
);
  import rest_pkg::*;

  // ==========================================================
  // event qualification
  logic [NUM_CNT-1:0] inc;
  logic [NUM_CNT-1:0] ovf;
  logic [NUM_CNT-1:0] wrap;
  logic [CNT_WIDTH-1:0] count [NUM_CNT];
  logic line_qual;
  logic clr_stats;
  logic ctrl_clr_pulse;

  assign line_qual = i_frame_copy_rep && !i_err_detect;
  always_comb
  begin
    inc = '0;
    inc[CNT_LINE] = line_qual && (i_cv_frame || i_cv_token || i_fcs_err_fmt1);
    inc[CNT_INTERNAL] = i_internal_err;
    inc[CNT_BURST] = i_burst_int;
    inc[CNT_ARFC] = i_own_return && !(i_ret_addr_rec && i_ret_copied);
    inc[CNT_ABORT] = i_abort_tx;
    inc[CNT_LOST] = i_tx_mode && i_frame_lost;
    inc[CNT_CONGEST] = i_rx_for_us_busy && i_no_buffer;
    inc[CNT_DUPADDR] = i_rx_own_addr && (i_rx_addr_rec || i_rx_copied);
    inc[CNT_FREQ] = i_freq_err;
    inc[CNT_TOKEN] = i_token_err;
  end

  // reset request from pin or from software both clear the whole set
  assign clr_stats = i_reset_stats || ctrl_clr_pulse;

  // ==========================================================
  // counters
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++)
    begin : g_cnt
      rest_counter #(
        .W(CNT_WIDTH)
      ) u_cnt (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_inc(inc[g]),
        .i_clr(clr_stats),
        .o_count(count[g]),
        .o_ovf(ovf[g]),
        .o_wrap(wrap[g])
      );
    end
  endgenerate

  // ==========================================================
  // ring status
  logic opened;
  logic sig_loss;
  logic hard_err;
  logic wire_fault;
  rest_link_status u_link (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_open_req(i_open_req),
    .i_sig_present(i_sig_present),
    .i_beacon_int(i_beacon_int),
    .i_beacon_rx(i_beacon_rx),
    .i_lobe_fault(i_lobe_fault),
    .o_opened(opened),
    .o_sig_loss(sig_loss),
    .o_hard_err(hard_err),
    .o_wire_fault(wire_fault),
    .o_insert(o_insert)
  );

  // ==========================================================
  // link count snapshot
  logic [LINK_W-1:0] links_active_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      links_active_reg <= '0;
    end
    else if (i_status_req)
    begin
      links_active_reg <= i_links_active;
    end
  end

  // ==========================================================
  // apb decode
  logic wr_en;
  logic rd_en;
  logic [31:0] addr_lo_reg;
  logic [23:0] addr_hi_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] rdata_next;
  logic [31:0] prdata_reg;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic wr_lo;
  logic wr_hi;

  function automatic logic is_cnt_addr(input logic [7:0] a);
    is_cnt_addr = (a >= OFS_CNT_BASE) && (a < OFS_CNT_BASE + 8'(NUM_CNT * 4)) && (a[1:0] == 2'b00);
  endfunction : is_cnt_addr

  function automatic logic reg_hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = en && (a == ofs);
  endfunction : reg_hit

  // writes land on the completing access edge, so an abandoned setup changes nothing
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  assign wr_ctrl = reg_hit(wr_en, i_paddr, OFS_CTRL);
  assign wr_stat = reg_hit(wr_en, i_paddr, OFS_IRQ_STAT);
  assign wr_mask = reg_hit(wr_en, i_paddr, OFS_IRQ_MASK);
  assign wr_lo = reg_hit(wr_en, i_paddr, OFS_ADDR_LO);
  assign wr_hi = reg_hit(wr_en, i_paddr, OFS_ADDR_HI);
  assign ctrl_clr_pulse = wr_ctrl && i_pwdata[CTRL_CLR_BIT];

  always_comb
  begin
    addr_ok = 1'b1;
    unique case (i_paddr)
      OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_ADDR_LO, OFS_ADDR_HI, OFS_LINKS, OFS_OVF: addr_ok = 1'b1;
      default: addr_ok = is_cnt_addr(i_paddr);
    endcase
  end

  // ==========================================================
  // station address
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      addr_lo_reg <= ADDR_LO_RST;
    end
    else if (wr_lo)
    begin
      addr_lo_reg <= i_pwdata;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      addr_hi_reg <= ADDR_HI_RST;
    end
    else if (wr_hi)
    begin
      addr_hi_reg <= i_pwdata[23:0];
    end
  end
  assign o_station_addr = {addr_hi_reg[15:0], addr_lo_reg};
  assign o_station_sap = addr_hi_reg[23:16];

  // ==========================================================
  // interrupts
  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_SIGLOSS_BIT] = sig_loss;
    irq_set[IRQ_HARDERR_BIT] = hard_err;
    irq_set[IRQ_WIREFLT_BIT] = wire_fault;
    irq_set[IRQ_OVF_BIT] = |wrap;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_stat_reg <= '0;
    end
    else if (wr_stat)
    begin
      irq_stat_reg <= (irq_stat_reg & ~i_pwdata[IRQ_W-1:0]) | irq_set;
    end
    else
    begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_mask_reg <= IRQ_MASK_RST;
    end
    else if (wr_mask)
    begin
      irq_mask_reg <= i_pwdata[IRQ_W-1:0];
    end
  end
  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // read data, captured in setup so access phase needs no wait
  logic [3:0] cnt_idx;
  assign cnt_idx = 4'((i_paddr - OFS_CNT_BASE) >> 2);

  always_comb
  begin
    rdata_next = APB_BAD_DATA;
    unique case (i_paddr)
      OFS_STATUS:
      begin
        rdata_next[ST_OPEN_BIT] = opened;
        rdata_next[ST_SIGLOSS_BIT] = sig_loss;
        rdata_next[ST_HARDERR_BIT] = hard_err;
        rdata_next[ST_WIREFLT_BIT] = wire_fault;
      end
      OFS_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
      OFS_ADDR_LO: rdata_next = addr_lo_reg;
      OFS_ADDR_HI: rdata_next[23:0] = addr_hi_reg;
      OFS_LINKS:
      begin
        rdata_next[LINK_W-1:0] = i_links_config;
        rdata_next[LINKS_ACT_POS +: LINK_W] = links_active_reg;
      end
      OFS_OVF: rdata_next[NUM_CNT-1:0] = ovf;
      default:
      begin
        if (is_cnt_addr(i_paddr) && cnt_idx < 4'(NUM_CNT))
        begin
          rdata_next[CNT_WIDTH-1:0] = count[cnt_idx];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      prdata_reg <= '0;
    end
    else if (rd_en)
    begin
      prdata_reg <= rdata_next;
    end
  end

  logic err_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      err_reg <= 1'b0;
    end
    else if (i_psel && !i_penable)
    begin
      err_reg <= !addr_ok;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && err_reg;
endmodule : rest_stats
`default_nettype wire

// ==== sim/rest_stats_asserts.sv ====
// Purpose: port assertions for rest_stats
// Assumes: apb answers without wait states
// Notes: bound to every rest_stats instance
`timescale 1ns/1ns
`default_nettype none
module rest_stats_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_open_req,
  input wire logic i_sig_present,
  input wire logic i_beacon_int,
  input wire logic i_beacon_rx,
  input wire logic i_lobe_fault,
  input wire logic o_insert,
  input wire logic [47:0] o_station_addr,
  input wire logic [7:0] o_station_sap
);
  import rest_pkg::*;
  // ====
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic bad_adr;
  assign bad_adr = (i_paddr[1:0] != 2'h0) || (i_paddr > 8'h44);
  sequence setup_s(logic [7:0] a, logic w);
    i_psel && !i_penable && (i_pwrite == w) && (i_paddr == a);
  endsequence
  // a write lands at the access edge that follows its setup
  sequence wr_done_s(logic [7:0] a);
    setup_s(a, 1'b1) ##1 (i_psel && i_penable && i_pwrite && (i_paddr == a));
  endsequence
  // status flops are stale on the edge right after reset
  sequence steady_rd_s(logic [7:0] a, logic v);
    setup_s(a, 1'b0) ##0 ($stable(v) && !$past(i_rst));
  endsequence
  // ====
  pready_a: assert property (o_pready) else $error("pready low");
  slverr_a: assert property (i_psel && i_penable |-> o_pslverr == bad_adr) else $error("pslverr wrong");
  close_a: assert property (!i_open_req |=> !o_insert) else $error("inserted while closed");
  fault_a: assert property (i_lobe_fault |-> ##[1:2] !o_insert) else $error("inserted on fault");
  sigloss_a: assert property (steady_rd_s(OFS_STATUS, i_sig_present) |=>
    o_prdata[ST_SIGLOSS_BIT] == !$past(i_sig_present)) else $error("signal loss bit wrong");
  harderr_a: assert property (steady_rd_s(OFS_STATUS, i_beacon_int | i_beacon_rx) |=>
    o_prdata[ST_HARDERR_BIT] == $past(i_beacon_int | i_beacon_rx)) else $error("hard error bit wrong");
  addr_lo_a: assert property (wr_done_s(OFS_ADDR_LO) |=>
    o_station_addr[31:0] == $past(i_pwdata)) else $error("address low wrong");
  addr_hi_a: assert property (wr_done_s(OFS_ADDR_HI) |=>
    {o_station_sap, o_station_addr[47:32]} == $past(i_pwdata[23:0])) else $error("address high wrong");
endmodule : rest_stats_chk
bind rest_stats rest_stats_chk i_rest_stats_chk (.*);
`default_nettype wire

// ==== sim/rest_ring_model.sv ====
// Purpose: ring stations and protocol handler as event source
// Assumes: one event per request, one cycle long
// Notes: qual low gives a look-alike that must not count, except kinds 1, 2, 4, 8 and 9, which ignore qual and always count
`timescale 1ns/1ns
`default_nettype none
module rest_ring_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_kind,
  input wire logic i_qual,
  output logic [19:0] o_ev
);
  logic [3:0] kind_reg = 4'hF;
  logic qual_reg = 1'b0;
  // ====
  // back to idle each cycle so no event is seen twice
  always_ff @(posedge i_clk)
  begin
    kind_reg <= i_go ? i_kind : 4'hF;
    qual_reg <= i_qual;
  end
  // ====
  // bit order follows the event ports of rest_stats
  always_comb
  begin
    o_ev = 20'h0;
    case (kind_reg)
      4'h0, 4'hA, 4'hB: o_ev[19:15] = {1'b1, !qual_reg, kind_reg == 4'h0, kind_reg == 4'hA, kind_reg == 4'hB};
      4'h1: o_ev[14] = 1'b1;
      4'h2: o_ev[13] = 1'b1;
      4'h3: o_ev[12:10] = {2'b11, !qual_reg};
      4'h4: o_ev[9] = 1'b1;
      4'h5: o_ev[8:7] = {qual_reg, 1'b1};
      4'h6: o_ev[6:5] = {1'b1, qual_reg};
      4'h7: o_ev[4:2] = {1'b1, qual_reg, 1'b0};
      4'h8: o_ev[1] = 1'b1;
      4'h9: o_ev[0] = 1'b1;
      default: o_ev = 20'h0;
    endcase
  end
endmodule : rest_ring_model
`default_nettype wire

// ==== sim/test_rest_stats.sv ====
// Purpose: self-checking bench for rest_stats
// Assumes: events come from rest_ring_model
// Notes: internal counter is driven round to test wrap
`timescale 1ns/1ns
`default_nettype none
module test_rest_stats;
  import rest_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic i_open_req = 1'b0, i_sig_present = 1'b1, i_beacon_int = 1'b0, i_beacon_rx = 1'b0;
  logic i_lobe_fault = 1'b0, i_reset_stats = 1'b0, i_status_req = 1'b0;
  logic [7:0] i_links_active = 8'h0, i_links_config = 8'h0;
  wire logic [31:0] o_prdata;
  wire logic o_pready, o_pslverr, o_insert, o_irq;
  wire logic [47:0] o_station_addr;
  wire logic [7:0] o_station_sap;
  wire logic [19:0] ev;
  wire logic i_frame_copy_rep, i_err_detect, i_cv_frame, i_cv_token, i_fcs_err_fmt1, i_internal_err, i_burst_int;
  wire logic i_own_return, i_ret_addr_rec, i_ret_copied, i_abort_tx, i_tx_mode, i_frame_lost, i_rx_for_us_busy;
  wire logic i_no_buffer, i_rx_own_addr, i_rx_addr_rec, i_rx_copied, i_freq_err, i_token_err;
  logic go = 1'b0, qual = 1'b0;
  logic [3:0] kind = 4'h0;
  logic [31:0] rd_v;
  logic err_v;
  logic [7:0] exp_c [10];
  logic [9:0] exp_ovf;
  int n_mismatch = 0, checks_done = 0;
  assign {i_frame_copy_rep, i_err_detect, i_cv_frame, i_cv_token, i_fcs_err_fmt1, i_internal_err, i_burst_int,
    i_own_return, i_ret_addr_rec, i_ret_copied, i_abort_tx, i_tx_mode, i_frame_lost, i_rx_for_us_busy,
    i_no_buffer, i_rx_own_addr, i_rx_addr_rec, i_rx_copied, i_freq_err, i_token_err} = ev;
  always #10 i_clk = ~i_clk;
  rest_stats i_rest_stats (.*);
  rest_ring_model i_rest_ring_model (.i_clk, .i_go(go), .i_kind(kind), .i_qual(qual), .o_ev(ev));
  // ====
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] s);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    for (n = 1; o_pready !== 1'b1 && n < 16; n++)
      @(posedge i_clk);
    if (o_pready !== 1'b1)
    begin
      chk("pready", 64'h1, 64'(o_pready));
      tally_and_finish();
    end
    rd_v = o_prdata;
    err_v = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, 64'(e), 64'(rd_v));
  endtask : rd
  task automatic clr_exp();
    foreach (exp_c[j])
      exp_c[j] = 8'h0;
    exp_ovf = 10'h0;
  endtask : clr_exp
  // one event, then its expected effect on the counters
  task automatic ev_send(input logic [3:0] k, input logic q);
    int i;
    i = (k > 4'h9) ? 0 : int'(k);
    go <= 1'b1;
    kind <= k;
    qual <= q;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (2) @(posedge i_clk);
    if (q || k inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h9})
    begin
      if (exp_c[i] == 8'hFF)
        exp_ovf[i] = 1'b1;
      exp_c[i] = exp_c[i] + 8'h1;
    end
  endtask : ev_send
  task automatic check_all();
    for (int j = 0; j < NUM_CNT; j++)
      rd(OFS_CNT_BASE + 8'(4 * j), {24'h0, exp_c[j]}, "counter");
    rd(OFS_OVF, {22'h0, exp_ovf}, "overflow");
  endtask : check_all
  // ====
  initial
  begin
    clr_exp();
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(OFS_IRQ_MASK, 32'h0, "mask");
    rd(8'h48, 32'h0, "unmapped");
    chk("slverr", 64'h1, 64'(err_v));
    wr(8'h4C, 32'hFF);
    chk("slverr", 64'h1, 64'(err_v));
    check_all();
    for (int k = 0; k < 12; k++)
    begin
      ev_send(4'(k), 1'b1);
      ev_send(4'(k), 1'b0);
    end
    check_all();
    wr(OFS_IRQ_MASK, 32'h8);
    repeat (255) ev_send(4'h1, 1'b1);
    check_all();
    rd(OFS_IRQ_STAT, 32'h8, "irq status");
    chk("irq", 64'h1, 64'(o_irq));
    wr(OFS_IRQ_STAT, 32'h8);
    chk("irq", 64'h0, 64'(o_irq));
    wr(OFS_CTRL, 32'h1);
    clr_exp();
    check_all();
    ev_send(4'h9, 1'b1);
    i_reset_stats <= 1'b1;
    @(posedge i_clk);
    i_reset_stats <= 1'b0;
    clr_exp();
    check_all();
    i_sig_present <= 1'b0;
    i_beacon_int <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(OFS_STATUS, 32'h6, "status");
    i_sig_present <= 1'b1;
    i_beacon_int <= 1'b0;
    i_beacon_rx <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(OFS_STATUS, 32'h4, "status");
    i_beacon_rx <= 1'b0;
    i_open_req <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(OFS_STATUS, 32'h1, "status");
    chk("insert", 64'h1, 64'(o_insert));
    i_lobe_fault <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(OFS_STATUS, 32'h8, "status");
    chk("insert", 64'h0, 64'(o_insert));
    rd(OFS_IRQ_STAT, 32'h7, "irq status");
    wr(OFS_IRQ_MASK, 32'h4);
    chk("irq", 64'h1, 64'(o_irq));
    i_lobe_fault <= 1'b0;
    i_open_req <= 1'b0;
    repeat (3) @(posedge i_clk);
    wr(OFS_IRQ_STAT, 32'h7);
    rd(OFS_IRQ_STAT, 32'h0, "irq status");
    chk("irq", 64'h0, 64'(o_irq));
    wr(OFS_ADDR_LO, 32'hA1B2C3D4);
    wr(OFS_ADDR_HI, 32'h00E5F607);
    chk("address", 64'hF607A1B2C3D4, 64'(o_station_addr));
    chk("sap", 64'hE5, 64'(o_station_sap));
    rd(OFS_ADDR_HI, 32'h00E5F607, "address high");
    i_links_active <= 8'h05;
    i_links_config <= 8'h09;
    i_status_req <= 1'b1;
    @(posedge i_clk);
    i_status_req <= 1'b0;
    i_links_active <= 8'h07;
    @(posedge i_clk);
    rd(OFS_LINKS, 32'h0509, "links");
    tally_and_finish();
  end
endmodule : test_rest_stats
`default_nettype wire
